//--- ppum_pkg.sv
`default_nettype none
package ppum_pkg;
  // Configuration register indices.
  localparam logic [7:0] IDX_PP_UART_MISC_CTRL = 8'h04;
  localparam logic [7:0] IDX_RESERVED_CFG_FIVE = 8'h05;
  localparam logic [7:0] IDX_RESERVED_CFG_SIX = 8'h06;
  localparam logic [7:0] IDX_AUTO_POWER_DOWN_CTRL = 8'h07;
  localparam logic [7:0] IDX_RESERVED_CFG_EIGHT = 8'h08;
  localparam logic [7:0] IDX_FACTORY_TEST_CTRL_FOUR = 8'h09;
  // Reset values.
  localparam logic [7:0] RST_PP_UART_MISC_CTRL = 8'h00;
  localparam logic [7:0] RST_AUTO_POWER_DOWN_CTRL = 8'h00;
  localparam logic [7:0] RST_FACTORY_TEST_CTRL_FOUR = 8'h00;
  // Writable bit masks; other bits read as zero.
  localparam logic [7:0] MASK_PP_UART_MISC_CTRL = 8'h53;
  localparam logic [7:0] MASK_AUTO_POWER_DOWN_CTRL = 8'h50;
  localparam logic [7:0] MASK_FACTORY_TEST_CTRL_FOUR = 8'hFF;
  // Field positions.
  localparam int PP_EXT_MODE_LSB = 0;
  localparam int MUSIC_CLK_BIT = 4;
  localparam int EPP_VER_BIT = 6;
  localparam int PP_AUTO_PD_BIT = 4;
  localparam int UART_AUTO_PD_BIT = 6;
  localparam int PP_PRINTER_MODE_BIT = 3;
  // Extended mode field and extended control register mode codes.
  localparam logic [1:0] EXT_SPP = 2'h0;
  localparam logic [1:0] EXT_EPP_SPP = 2'h1;
  localparam logic [1:0] EXT_ECP = 2'h2;
  localparam logic [1:0] EXT_ECP_EPP = 2'h3;
  localparam logic [2:0] ECR_MODE_SPP = 3'h0;
  localparam logic [2:0] ECR_MODE_EPP = 3'h4;
  // Music serial link: 31.25 kbaud, 16x oversampled, from 200 MHz.
  localparam int CLK_HZ = 200_000_000;
  localparam int MUSIC_BAUD = 31_250;
  localparam int MUSIC_OVERSAMPLE = 16;
  localparam int MUSIC_DIV = CLK_HZ / (MUSIC_BAUD * MUSIC_OVERSAMPLE);
  localparam logic [8:0] MUSIC_DIV_LAST = 9'(MUSIC_DIV - 1);
  // Effective parallel port operating modes.
  typedef enum logic [2:0] {
    PM_PRINTER = 3'b000,
    PM_SPP = 3'b001,
    PM_EPP = 3'b010,
    PM_ECP = 3'b011
  } ppum_pmode_t;
endpackage
`default_nettype wire

//--- ppum_mode_sel.sv
`default_nettype none
module ppum_mode_sel (
  // Controls.
  input wire logic printer_mode,
  input wire logic [1:0] ext_mode,
  input wire logic [2:0] ecr_mode,
  // Result.
  output ppum_pkg::ppum_pmode_t pmode
);
  // Printer mode overrides; ECP settings defer to the ecr mode field.
  always_comb begin
    pmode = ppum_pkg::PM_SPP;
    if (printer_mode) begin
      pmode = ppum_pkg::PM_PRINTER;
    end else begin
      case (ext_mode)
        ppum_pkg::EXT_SPP: pmode = ppum_pkg::PM_SPP;
        ppum_pkg::EXT_EPP_SPP: pmode = ppum_pkg::PM_EPP;
        ppum_pkg::EXT_ECP: begin
          pmode = (ecr_mode == ppum_pkg::ECR_MODE_SPP) ? ppum_pkg::PM_SPP
                                                      : ppum_pkg::PM_ECP;
        end
        ppum_pkg::EXT_ECP_EPP: begin
          if (ecr_mode == ppum_pkg::ECR_MODE_EPP) begin
            pmode = ppum_pkg::PM_EPP;
          end else if (ecr_mode == ppum_pkg::ECR_MODE_SPP) begin
            pmode = ppum_pkg::PM_SPP;
          end else begin
            pmode = ppum_pkg::PM_ECP;
          end
        end
        default: pmode = ppum_pkg::PM_SPP;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- ppum_baud_tick.sv
`default_nettype none
module ppum_baud_tick (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control and tick.
  input wire logic enable,
  output logic tick
);
  logic [8:0] cnt_r;
  // Divider for the 16x music baud clock; 200 MHz / 400 is exact, so 0 percent error.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_r <= 9'h000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == ppum_pkg::MUSIC_DIV_LAST);
      cnt_r <= (cnt_r == ppum_pkg::MUSIC_DIV_LAST) ? 9'h000 : cnt_r + 9'h001;
    end
  end
endmodule
`default_nettype wire

//--- ppum_cfg_regs.sv
// Contract
// - Registers 04h, 07h, 09h are reachable only in configuration state with the index set.
// - Printer mode bit high forces printer mode; low lets the extended mode field apply.
// - Extended mode field 00 STANDARD_PARALLEL_MODE, 01 EPP and STANDARD_PARALLEL_MODE, 10 ECP, 11 ECP with EPP; default 00.
// - In ECP with EPP, ecr mode 100 enters EPP operation.
// - In the ECP settings, ecr mode 000 falls back to standard parallel operation.
// - Bits 2, 3, 5 and 7 of register 04h read as zero.
// - Bit 4 of register 04h enables the music serial clock option, default off.
// - With that option on, the serial port runs at 31.25 kbaud within one percent.
// - Bit 6 of register 04h picks EPP 1.9 when zero and EPP 1.7 when one.
// - Registers 04h, 07h and 09h clear to zero on power-on reset.
// - Hardware reset clears bits 7 to 4 of register 07h.
// - Bit 4 of register 07h enables parallel port auto power-down.
// - Bit 6 of register 07h enables UART auto power-down.
// - Bits 0 to 3, 5 and 7 of register 07h read as zero.
// - Registers 05h, 06h and 08h read as zero.
`default_nettype none
module ppum_cfg_regs (
  // Clock and resets.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HARD_RST,
  // Configuration access.
  input wire logic CFG_STATE,
  input wire logic [7:0] CONFIG_SELECT_INDEX,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_HIT,
  // Neighbouring state.
  input wire logic PP_PRINTER_MODE,
  input wire logic [2:0] ECR_MODE,
  // Decoded controls.
  output logic [2:0] PP_MODE,
  output logic [1:0] PP_EXT_MODE,
  output logic EPP_VERSION_SEL,
  output logic MUSIC_SERIAL_CLOCK_SEL,
  output logic MUSIC_BAUD_TICK,
  output logic PP_AUTO_PD_EN,
  output logic UART_AUTO_PD_EN,
  output logic [7:0] FACTORY_TEST
);
  logic rst_s1_r;
  logic rst_n_r;
  logic [7:0] misc_r;
  logic [7:0] apd_r;
  logic [7:0] test_r;
  logic acc_ok;
  logic [7:0] rd_nxt;
  logic tick_w;
  ppum_pkg::ppum_pmode_t pmode_w;

  // Returns true when the index selects a register of this slice.
  function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
    idx_is = (idx == want);
  endfunction

  // Reset release is synchronised so all flops leave reset on the same edge.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Access qualifier: configuration state only.
  assign acc_ok = CFG_STATE;

  // Misc control register; only implemented bits store, others stay zero.
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      misc_r <= ppum_pkg::RST_PP_UART_MISC_CTRL;
    end else if (acc_ok && CFG_WR &&
                 idx_is(CONFIG_SELECT_INDEX, ppum_pkg::IDX_PP_UART_MISC_CTRL)) begin
      misc_r <= CFG_WDATA & ppum_pkg::MASK_PP_UART_MISC_CTRL;
    end
  end

  // Auto power-down register; hardware reset also clears the upper nibble.
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      apd_r <= ppum_pkg::RST_AUTO_POWER_DOWN_CTRL;
    end else if (HARD_RST) begin
      apd_r <= ppum_pkg::RST_AUTO_POWER_DOWN_CTRL;
    end else if (acc_ok && CFG_WR &&
                 idx_is(CONFIG_SELECT_INDEX, ppum_pkg::IDX_AUTO_POWER_DOWN_CTRL)) begin
      apd_r <= CFG_WDATA & ppum_pkg::MASK_AUTO_POWER_DOWN_CTRL;
    end
  end

  // Test register stores all bits; software is expected to leave it zero.
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      test_r <= ppum_pkg::RST_FACTORY_TEST_CTRL_FOUR;
    end else if (acc_ok && CFG_WR &&
                 idx_is(CONFIG_SELECT_INDEX, ppum_pkg::IDX_FACTORY_TEST_CTRL_FOUR)) begin
      test_r <= CFG_WDATA & ppum_pkg::MASK_FACTORY_TEST_CTRL_FOUR;
    end
  end

  // Read mux; reserved registers and unselected indices return zero.
  always_comb begin
    rd_nxt = 8'h00;
    case (CONFIG_SELECT_INDEX)
      ppum_pkg::IDX_PP_UART_MISC_CTRL: rd_nxt = misc_r;
      ppum_pkg::IDX_AUTO_POWER_DOWN_CTRL: rd_nxt = apd_r;
      ppum_pkg::IDX_FACTORY_TEST_CTRL_FOUR: rd_nxt = test_r;
      ppum_pkg::IDX_RESERVED_CFG_FIVE: rd_nxt = 8'h00;
      ppum_pkg::IDX_RESERVED_CFG_SIX: rd_nxt = 8'h00;
      ppum_pkg::IDX_RESERVED_CFG_EIGHT: rd_nxt = 8'h00;
      default: rd_nxt = 8'h00;
    endcase
  end

  // Registered read data one cycle after the read strobe; hit flag one cycle after a read or write strobe.
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      CFG_RDATA <= 8'h00;
      CFG_HIT <= 1'b0;
    end else begin
      CFG_RDATA <= (acc_ok && CFG_RD) ? rd_nxt : 8'h00;
      CFG_HIT <= acc_ok && (CFG_RD || CFG_WR) &&
                 (CONFIG_SELECT_INDEX >= ppum_pkg::IDX_PP_UART_MISC_CTRL) &&
                 (CONFIG_SELECT_INDEX <= ppum_pkg::IDX_FACTORY_TEST_CTRL_FOUR);
    end
  end

  // Effective parallel port mode decode.
  ppum_mode_sel u_mode (
    .printer_mode(PP_PRINTER_MODE),
    .ext_mode(misc_r[ppum_pkg::PP_EXT_MODE_LSB +: 2]),
    .ecr_mode(ECR_MODE),
    .pmode(pmode_w)
  );

  // Music baud divider runs only while the option is enabled.
  ppum_baud_tick u_tick (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .enable(misc_r[ppum_pkg::MUSIC_CLK_BIT]),
    .tick(tick_w)
  );

  // Control outputs are registered copies so every port comes from a flop.
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PP_MODE <= 3'h0;
      PP_EXT_MODE <= ppum_pkg::EXT_SPP;
      EPP_VERSION_SEL <= 1'b0;
      MUSIC_SERIAL_CLOCK_SEL <= 1'b0;
      MUSIC_BAUD_TICK <= 1'b0;
      PP_AUTO_PD_EN <= 1'b0;
      UART_AUTO_PD_EN <= 1'b0;
      FACTORY_TEST <= 8'h00;
    end else begin
      PP_MODE <= pmode_w;
      PP_EXT_MODE <= misc_r[ppum_pkg::PP_EXT_MODE_LSB +: 2];
      EPP_VERSION_SEL <= misc_r[ppum_pkg::EPP_VER_BIT];
      MUSIC_SERIAL_CLOCK_SEL <= misc_r[ppum_pkg::MUSIC_CLK_BIT];
      MUSIC_BAUD_TICK <= tick_w;
      PP_AUTO_PD_EN <= apd_r[ppum_pkg::PP_AUTO_PD_BIT];
      UART_AUTO_PD_EN <= apd_r[ppum_pkg::UART_AUTO_PD_BIT];
      FACTORY_TEST <= test_r;
    end
  end
endmodule
`default_nettype wire

//--- ppum_cfg_regs_sva.sv
`default_nettype none
module ppum_chk (
  // Clock, reset and access.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HARD_RST,
  input wire logic CFG_STATE,
  input wire logic [7:0] CONFIG_SELECT_INDEX,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_RDATA,
  input wire logic CFG_HIT,
  // Mode inputs and controls.
  input wire logic PP_PRINTER_MODE,
  input wire logic [2:0] ECR_MODE,
  input wire logic [2:0] PP_MODE,
  input wire logic [1:0] PP_EXT_MODE,
  input wire logic EPP_VERSION_SEL,
  input wire logic MUSIC_SERIAL_CLOCK_SEL,
  input wire logic PP_AUTO_PD_EN,
  input wire logic UART_AUTO_PD_EN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic rd;
  logic [7:0] ix;
  logic [2:0] em;
  // Expected mode; ECP alone with ecr 100 is left open and is not judged.
  assign ix = CONFIG_SELECT_INDEX;
  assign rd = CFG_STATE && CFG_RD;
  assign em = PP_PRINTER_MODE ? 3'h0 : PP_EXT_MODE == 2'h1 ? 3'h2 :
    (!PP_EXT_MODE[1] || ECR_MODE == 3'h0) ? 3'h1 : ECR_MODE == 3'h4 ? 3'h2 : 3'h3;
  a_hit_cause: assert property (CFG_HIT |-> $past(CFG_STATE && (CFG_WR || CFG_RD)
    && ix >= 8'h04 && ix <= 8'h09)) else $error("stray hit");
  a_idle_rdata: assert property (!$past(rd) |-> CFG_RDATA == 8'h00)
    else $error("stray read data");
  a_misc_rsvd: assert property ($past(rd && ix == 8'h04) |-> (CFG_RDATA & 8'hAC) == 8'h00)
    else $error("04h reserved set");
  a_misc_fields: assert property ($past(rd && ix == 8'h04) |->
    CFG_RDATA[1:0] == PP_EXT_MODE && CFG_RDATA[4] == MUSIC_SERIAL_CLOCK_SEL
    && CFG_RDATA[6] == EPP_VERSION_SEL) else $error("04h fields");
  a_apd_bits: assert property ($past(rd && ix == 8'h07) |-> CFG_RDATA ==
    {1'b0, UART_AUTO_PD_EN, 1'b0, PP_AUTO_PD_EN, 4'h0}) else $error("07h read");
  a_rsvd_regs: assert property ($past(rd && (ix == 8'h05 || ix == 8'h06 || ix == 8'h08))
    |-> CFG_RDATA == 8'h00) else $error("reserved register");
  a_hard_clear: assert property (HARD_RST ##1 !CFG_WR |->
    ##1 !PP_AUTO_PD_EN && !UART_AUTO_PD_EN) else $error("hard reset");
  a_mode_decode: assert property (
    ($stable({PP_PRINTER_MODE, PP_EXT_MODE, ECR_MODE})
    && $past(RST_B, 2) && $past(RST_B, 3) && !(PP_EXT_MODE == 2'h2 && ECR_MODE == 3'h4))[*2]
    |-> PP_MODE == em) else $error("parallel mode");
  c_write: cover property (CFG_WR && CFG_STATE);
  c_hard: cover property (HARD_RST);
  c_epp: cover property (PP_MODE == 3'h2 && PP_EXT_MODE == 2'h3);
endmodule
bind ppum_cfg_regs ppum_chk chk (.CLK_SYS, .RST_B, .HARD_RST, .CFG_STATE, .CONFIG_SELECT_INDEX,
  .CFG_WR, .CFG_RD, .CFG_RDATA, .CFG_HIT, .PP_PRINTER_MODE, .ECR_MODE, .PP_MODE, .PP_EXT_MODE,
  .EPP_VERSION_SEL, .MUSIC_SERIAL_CLOCK_SEL, .PP_AUTO_PD_EN, .UART_AUTO_PD_EN);
`default_nettype wire

//--- ppum_host.sv
`default_nettype none
module ppum_host (
  // Clock and answer.
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic hit,
  // Access lines.
  output logic st,
  output logic [7:0] ix,
  output logic wr,
  output logic rd,
  output logic [7:0] wd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {st, ix, wr, rd, wd} = '0;
  // Index and strobe rise together; released data shows its inverse.
  task automatic acc(input logic w, input logic [7:0] i, d, output logic [7:0] q, output logic h);
    @(posedge clk) #1;
    {ix, wd, wr, rd} = {i, d, w, !w};
    @(posedge clk) #1;
    {wd, wr, rd} = {~d, 2'b00};
    q = rdata;
    h = hit;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, hrst = 1'b0, prn = 1'b1;
  logic st, wr, rd, hit, epp, mus, tk, pa, ua, h;
  logic [7:0] ix, wd, rdat, ft, q;
  logic [2:0] ecr = 3'h0, pm;
  logic [1:0] ext;
  logic [7:0] msk [6] = '{8'h53, 8'h00, 8'h00, 8'h50, 8'h00, 8'hFF};
  logic [2:0] em [4][3] = '{'{3'h1, 3'h1, 3'h1}, '{3'h2, 3'h2, 3'h2}, '{3'h1, 3'h3, 3'h0},
    '{3'h1, 3'h3, 3'h2}};
  int n_fail = 0, check_count = 0, n = 0;
  // Free running 200 MHz clock.
  always #2.5 clk = ~clk;
  ppum_host host (.clk(clk), .rdata(rdat), .hit(hit), .st(st), .ix(ix), .wr(wr), .rd(rd),
    .wd(wd));
  ppum_cfg_regs uut (.CLK_SYS(clk), .RST_B(rst_b), .HARD_RST(hrst), .CFG_STATE(st),
    .CONFIG_SELECT_INDEX(ix), .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wd), .CFG_RDATA(rdat),
    .CFG_HIT(hit), .PP_PRINTER_MODE(prn), .ECR_MODE(ecr), .PP_MODE(pm), .PP_EXT_MODE(ext),
    .EPP_VERSION_SEL(epp), .MUSIC_SERIAL_CLOCK_SEL(mus), .MUSIC_BAUD_TICK(tk),
    .PP_AUTO_PD_EN(pa), .UART_AUTO_PD_EN(ua), .FACTORY_TEST(ft));
  task automatic chk(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A write also checks the hit flag, expected only in configuration state and in range.
  task automatic wrc(input logic [7:0] i, d);
    logic eh;
    eh = st && i >= 8'h04 && i <= 8'h09;
    host.acc(1'b1, i, d, q, h);
    chk("whit", 16'(eh), 16'(h));
  endtask
  // A read also checks the hit flag, expected only in configuration state and for an index in range.
  task automatic rdc(input logic [7:0] i, e);
    logic eh;
    eh = st && i >= 8'h04 && i <= 8'h09;
    host.acc(1'b0, i, 8'h00, q, h);
    chk("rdata", 16'(e), 16'(q));
    chk("hit", 16'(eh), 16'(h));
  endtask
  task automatic rst();
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    // Step off the edge so the caller never changes an input as the design samples it.
    #1;
  endtask
  // Counts cycles up to the next tick, bounded so a dead divider cannot hang.
  task automatic tick();
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (tk !== 1'b1 && n < 1000);
    if (tk !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    rst();
    host.st = 1'b1;
    for (int i = 4; i < 10; i++) rdc(8'(i), 8'h00);
    for (int i = 4; i < 10; i++) wrc(8'(i), 8'hFF);
    for (int i = 4; i < 10; i++) rdc(8'(i), msk[i - 4]);
    chk("ctl", 16'h003F, 16'({ext, epp, mus, pa, ua}));
    chk("test", 16'h00FF, 16'(ft));
    tick();
    tick();
    chk("gap", 16'h0190, 16'(n));
    host.st = 1'b0;
    wrc(8'h04, 8'h00);
    rdc(8'h04, 8'h00);
    host.st = 1'b1;
    rdc(8'h04, 8'h53);
    chk("pm", 16'h0000, 16'(pm));
    prn = 1'b0;
    for (int e = 0; e < 4; e++) begin
      wrc(8'h04, 8'(e));
      for (int k = 0; k < 3; k++) begin
        ecr = (k == 2) ? 3'h4 : 3'(k);
        repeat (3) @(posedge clk);
        #1 if (e != 2 || k != 2) chk("pm", 16'(em[e][k]), 16'(pm));
      end
    end
    // The music bit is clear now, so the divider must stay silent for a full period.
    n = 0;
    repeat (450) @(posedge clk) #1 n += int'(tk === 1'b1);
    chk("quiet", 16'h0000, 16'(n));
    prn = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("pm", 16'h0000, 16'(pm));
    wrc(8'h07, 8'hFF);
    hrst = 1'b1;
    @(posedge clk) #1 hrst = 1'b0;
    rdc(8'h07, 8'h00);
    rdc(8'h04, 8'h03);
    wrc(8'h09, 8'h00);
    rdc(8'h09, 8'h00);
    wrc(8'h04, 8'hFF);
    wrc(8'h07, 8'hFF);
    wrc(8'h09, 8'hFF);
    rst();
    rdc(8'h04, 8'h00);
    rdc(8'h07, 8'h00);
    rdc(8'h09, 8'h00);
    chk("ctl", 16'h0000, 16'({ext, epp, mus, pa, ua}));
    chk("test", 16'h0000, 16'(ft));
    report_and_stop();
  end
endmodule
`default_nettype wire
